// >>> inc/stm_pkg.sv
// Package for the split-capable timer: constants, encodings and carrier types.
// Assumes a single peripheral clock; all control bits arrive as plain ports.
package stm_pkg;
    localparam int CNT_W = 16;
    localparam int BYTE_W = 8;
    localparam int NUM_CMP = 3;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] PER_RESET = 16'hFFFF;
    localparam logic [15:0] BOTTOM = 16'h0000;
    localparam logic [7:0] BOTTOM8 = 8'h00;
    localparam logic [9:0] PRESCALE_RESET = 10'h000;
    // Flag bit positions.
    localparam int FLAG_OVF = 0;
    localparam int FLAG_HIGH_UNDERFLOW = 1;
    localparam int FLAG_COMPARE_ZERO = 4;
    localparam int FLAG_W = 8;

    typedef enum logic [2:0]
    {
        STM_DIV1 = 3'h0,
        STM_DIV2 = 3'h1,
        STM_DIV4 = 3'h2,
        STM_DIV8 = 3'h3,
        STM_DIV16 = 3'h4,
        STM_DIV64 = 3'h5,
        STM_DIV256 = 3'h6,
        STM_DIV1024 = 3'h7
    } stm_prescale_t;

    typedef enum logic [2:0]
    {
        STM_EV_POSEDGE = 3'h0,
        STM_EV_ANYEDGE = 3'h1,
        STM_EV_HIGH = 3'h2,
        STM_EV_DIR = 3'h3
    } stm_event_action_select_t;

    typedef enum logic [2:0]
    {
        STM_WG_NORMAL = 3'h0,
        STM_WG_FRQ = 3'h1,
        STM_WG_SINGLE_SLOPE_PWM = 3'h3,
        STM_WG_DSTOP = 3'h5
    } stm_waveform_mode_select_t;

    // Event outputs, one-cycle pulses.
    typedef struct packed
    {
        logic overflow_or_low_underflow_event;
        logic high_underflow;
        logic [2:0] cmp;
    } stm_events_t;

    // Control configuration.
    typedef struct packed
    {
        logic enable;
        stm_prescale_t prescale_select;
        logic split_mode_enable;
        stm_waveform_mode_select_t waveform_mode_select;
        stm_event_action_select_t event_action_select;
        logic count_on_event_enable;
        logic dir_down;
    } stm_ctrl_t;
endpackage

// >>> src/stm_timer.sv
// Timer core with normal and split operation, events and interrupt flags.
// Assumes event input comes from another domain and is synchronised here;
// software writes arrive as strobes on the peripheral clock.
`timescale 1ns/1ns
module stm_timer
(
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Control
    input wire stm_pkg::stm_ctrl_t CTRL,
    input wire logic [7:0] INT_ENABLE,
    input wire logic [7:0] FLAG_CLEAR,
    input wire logic IDLE_SLEEP,
    // Counter, period and compare writes
    input wire logic [1:0] CNT_WE,
    input wire logic [15:0] CNT_WDATA,
    input wire logic [1:0] PER_WE,
    input wire logic [15:0] PER_WDATA,
    input wire logic [2:0][1:0] CMP_WE,
    input wire logic [15:0] CMP_WDATA,
    // Event input
    input wire logic EVENT_IN,
    // Status
    output logic [15:0] CNT,
    output logic [15:0] PER,
    output logic [2:0][15:0] CMP,
    output logic [7:0] INTERRUPT_FLAG,
    output logic IRQ,
    output stm_pkg::stm_events_t EVENTS,
    output logic [5:0] WAVE_OUT
);
    logic ev_meta;
    logic ev_sync;
    logic ev_prev;
    logic [9:0] prescale_cnt;
    logic tick;
    logic ev_pos;
    logic ev_any;
    logic count_ok;
    logic dir_down;
    logic split;
    logic [15:0] next_cnt;
    logic ovf_cond;
    logic high_underflow_cond;
    logic [2:0] cmp_cond;
    logic [9:0] div_mask;
    logic low_bottom;
    logic high_bottom;

    assign split = CTRL.split_mode_enable;

    // The first stage is read only by the second; the second also feeds edge detection, level gating and direction.
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            ev_meta <= 1'b0;
            ev_sync <= 1'b0;
            ev_prev <= 1'b0;
        end
        else
        begin
            ev_meta <= EVENT_IN;
            ev_sync <= ev_meta;
            ev_prev <= ev_sync;
        end
    end

    assign ev_pos = ev_sync && !ev_prev;
    assign ev_any = ev_sync ^ ev_prev;

    always_comb
    begin
        unique case (CTRL.prescale_select)
            stm_pkg::STM_DIV1: div_mask = 10'h000;
            stm_pkg::STM_DIV2: div_mask = 10'h001;
            stm_pkg::STM_DIV4: div_mask = 10'h003;
            stm_pkg::STM_DIV8: div_mask = 10'h007;
            stm_pkg::STM_DIV16: div_mask = 10'h00F;
            stm_pkg::STM_DIV64: div_mask = 10'h03F;
            stm_pkg::STM_DIV256: div_mask = 10'h0FF;
            stm_pkg::STM_DIV1024: div_mask = 10'h3FF;
        endcase
    end

    // Sleep never gates the prescaler: the timer keeps running through idle sleep.
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            prescale_cnt <= stm_pkg::PRESCALE_RESET;
        else if (!CTRL.enable)
            prescale_cnt <= stm_pkg::PRESCALE_RESET;
        else
            prescale_cnt <= prescale_cnt + 10'h001;
    end

    assign tick = CTRL.enable && ((prescale_cnt & div_mask) == div_mask);

    // Event gating: ignored entirely in split mode.
    always_comb
    begin
        count_ok = tick;
        dir_down = CTRL.dir_down;
        if (!split && CTRL.count_on_event_enable)
        begin
            unique case (CTRL.event_action_select)
                stm_pkg::STM_EV_POSEDGE: count_ok = tick && ev_pos;
                stm_pkg::STM_EV_ANYEDGE: count_ok = tick && ev_any;
                stm_pkg::STM_EV_HIGH: count_ok = tick && ev_sync;
                stm_pkg::STM_EV_DIR: dir_down = ev_sync;
                default: count_ok = tick;
            endcase
        end
    end

    assign low_bottom = CNT[7:0] == stm_pkg::BOTTOM8;
    assign high_bottom = CNT[15:8] == stm_pkg::BOTTOM8;

    // Counter next value. Buffers are not modelled, so split mode has none to use.
    always_comb
    begin
        next_cnt = CNT;
        ovf_cond = 1'b0;
        high_underflow_cond = 1'b0;
        if (split)
        begin
            if (tick)
            begin
                next_cnt[7:0] = low_bottom ? PER[7:0] : CNT[7:0] - 8'h01;
                next_cnt[15:8] = high_bottom ? PER[15:8] : CNT[15:8] - 8'h01;
                ovf_cond = low_bottom;
                high_underflow_cond = high_bottom;
            end
        end
        else if (count_ok)
        begin
            if (dir_down)
            begin
                next_cnt = (CNT == stm_pkg::BOTTOM) ? PER : CNT - 16'h0001;
                ovf_cond = CNT == stm_pkg::BOTTOM;
            end
            else
            begin
                next_cnt = (CNT >= PER) ? stm_pkg::BOTTOM : CNT + 16'h0001;
                ovf_cond = CNT >= PER;
            end
        end
    end

    // Compare conditions: only the low timer in split mode.
    always_comb
    begin
        for (int i = 0; i < stm_pkg::NUM_CMP; i++)
        begin
            if (split)
                cmp_cond[i] = tick && (CNT[7:0] == CMP[i][7:0]);
            else
                cmp_cond[i] = count_ok && (CNT == CMP[i]);
        end
    end

    // Byte writes land directly; the mode bit never rewrites stored values.
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            CNT <= stm_pkg::CNT_RESET;
        else
        begin
            CNT[7:0] <= CNT_WE[0] ? CNT_WDATA[7:0] : next_cnt[7:0];
            CNT[15:8] <= CNT_WE[1] ? CNT_WDATA[15:8] : next_cnt[15:8];
        end
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            PER <= stm_pkg::PER_RESET;
        else
        begin
            if (PER_WE[0])
                PER[7:0] <= PER_WDATA[7:0];
            if (PER_WE[1])
                PER[15:8] <= PER_WDATA[15:8];
        end
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            CMP <= '0;
        else
        begin
            for (int i = 0; i < stm_pkg::NUM_CMP; i++)
            begin
                if (CMP_WE[i][0])
                    CMP[i][7:0] <= CMP_WDATA[7:0];
                if (CMP_WE[i][1])
                    CMP[i][15:8] <= CMP_WDATA[15:8];
            end
        end
    end

    // Flags: a set in the same cycle as its clear wins.
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            INTERRUPT_FLAG <= 8'h00;
        else
        begin
            INTERRUPT_FLAG <= INTERRUPT_FLAG & ~FLAG_CLEAR;
            if (ovf_cond)
                INTERRUPT_FLAG[stm_pkg::FLAG_OVF] <= 1'b1;
            if (high_underflow_cond)
                INTERRUPT_FLAG[stm_pkg::FLAG_HIGH_UNDERFLOW] <= 1'b1;
            for (int i = 0; i < stm_pkg::NUM_CMP; i++)
            begin
                if (cmp_cond[i])
                    INTERRUPT_FLAG[stm_pkg::FLAG_COMPARE_ZERO + i] <= 1'b1;
            end
        end
    end

    assign IRQ = |(INTERRUPT_FLAG & INT_ENABLE);

    // Events share the flag conditions exactly, registered to one-cycle pulses.
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            EVENTS <= '0;
        else
        begin
            EVENTS.overflow_or_low_underflow_event <= ovf_cond;
            EVENTS.high_underflow <= high_underflow_cond && split;
            EVENTS.cmp <= cmp_cond;
        end
    end

    // Single-slope PWM: high from bottom, low once the counter reaches compare.
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            WAVE_OUT <= 6'h00;
        else
        begin
            for (int i = 0; i < stm_pkg::NUM_CMP; i++)
            begin
                if (split)
                begin
                    WAVE_OUT[i] <= CNT[7:0] < CMP[i][7:0];
                    WAVE_OUT[i + stm_pkg::NUM_CMP] <= CNT[15:8] < CMP[i][15:8];
                end
                else
                begin
                    WAVE_OUT[i] <= (CTRL.waveform_mode_select == stm_pkg::STM_WG_SINGLE_SLOPE_PWM)
                        && (CNT < CMP[i]);
                    WAVE_OUT[i + stm_pkg::NUM_CMP] <= 1'b0;
                end
            end
        end
    end

    property p_high_underflow_split_only;
        @(posedge CLK) disable iff (!NRST) !split |=> !EVENTS.high_underflow;
    endproperty
    a_high_underflow_split_only: assert property (p_high_underflow_split_only) else $error("high_underflow outside split");

    property p_event_flag;
        @(posedge CLK) disable iff (!NRST)
            ovf_cond |=> EVENTS.overflow_or_low_underflow_event && INTERRUPT_FLAG[stm_pkg::FLAG_OVF];
    endproperty
    a_event_flag: assert property (p_event_flag) else $error("event and flag differ");

    property p_pulse;
        @(posedge CLK) disable iff (!NRST) EVENTS.overflow_or_low_underflow_event && !ovf_cond |=> !EVENTS.overflow_or_low_underflow_event;
    endproperty
    a_pulse: assert property (p_pulse) else $error("event not one cycle");

    property p_irq;
        @(posedge CLK) disable iff (!NRST)
            INTERRUPT_FLAG[stm_pkg::FLAG_COMPARE_ZERO] && INT_ENABLE[stm_pkg::FLAG_COMPARE_ZERO] |-> IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");

    property p_reload;
        @(posedge CLK) disable iff (!NRST)
            split && tick && low_bottom && !CNT_WE[0] |=> CNT[7:0] == $past(PER[7:0]);
    endproperty
    a_reload: assert property (p_reload) else $error("low reload wrong");

    property p_down;
        @(posedge CLK) disable iff (!NRST)
            split && tick && !high_bottom && !CNT_WE[1] |=> CNT[15:8] == $past(CNT[15:8]) - 8'h01;
    endproperty
    a_down: assert property (p_down) else $error("high not counting down");

    property p_high_underflow;
        @(posedge CLK) disable iff (!NRST)
            split && tick && high_bottom |=> INTERRUPT_FLAG[stm_pkg::FLAG_HIGH_UNDERFLOW] && EVENTS.high_underflow;
    endproperty
    a_high_underflow: assert property (p_high_underflow) else $error("high_underflow not raised");

    property p_no_event_split;
        @(posedge CLK) disable iff (!NRST) split |-> count_ok == tick;
    endproperty
    a_no_event_split: assert property (p_no_event_split) else $error("event used in split");

    property p_gate;
        @(posedge CLK) disable iff (!NRST)
            !split && !CTRL.count_on_event_enable |-> count_ok == tick;
    endproperty
    a_gate: assert property (p_gate) else $error("event gated while disabled");

    property p_low_underflow;
        @(posedge CLK) disable iff (!NRST)
            split && tick && low_bottom |=> INTERRUPT_FLAG[stm_pkg::FLAG_OVF] && EVENTS.overflow_or_low_underflow_event;
    endproperty
    a_low_underflow: assert property (p_low_underflow) else $error("low underflow not raised");

    property p_low_cmp;
        @(posedge CLK) disable iff (!NRST)
            split && tick && CNT[7:0] == CMP[0][7:0]
            |=> EVENTS.cmp[0] && INTERRUPT_FLAG[stm_pkg::FLAG_COMPARE_ZERO];
    endproperty
    a_low_cmp: assert property (p_low_cmp) else $error("low compare not raised");

    property p_hcmp;
        @(posedge CLK) disable iff (!NRST)
            split && !(tick && CNT[7:0] == CMP[0][7:0]) && !INTERRUPT_FLAG[stm_pkg::FLAG_COMPARE_ZERO]
            |=> !INTERRUPT_FLAG[stm_pkg::FLAG_COMPARE_ZERO];
    endproperty
    a_hcmp: assert property (p_hcmp) else $error("high compare flagged");

    property p_dir;
        @(posedge CLK) disable iff (!NRST)
            !split && CTRL.count_on_event_enable && CTRL.event_action_select == stm_pkg::STM_EV_DIR
            && count_ok && ev_sync && CNT != stm_pkg::BOTTOM && CNT_WE == 2'h0
            |=> CNT == $past(CNT) - 16'h0001;
    endproperty
    a_dir: assert property (p_dir) else $error("direction event ignored");

    property p_idle;
        @(posedge CLK) disable iff (!NRST)
            IDLE_SLEEP && CTRL.enable |=> prescale_cnt == $past(prescale_cnt) + 10'h001;
    endproperty
    a_idle: assert property (p_idle) else $error("prescaler stalled in idle");
endmodule // stm_timer

// >>> tb/tb.sv
// Self-checking bench for the split-capable timer: split counting, events, flags and event input.
// Assumes the timer core from src and its package; all control bits are driven as plain ports.
`timescale 1ns/1ns
module tb;
    logic CLK;
    logic NRST;
    stm_pkg::stm_ctrl_t CTRL;
    logic [7:0] INT_ENABLE;
    logic [7:0] FLAG_CLEAR;
    logic IDLE_SLEEP;
    logic [1:0] CNT_WE;
    logic [15:0] CNT_WDATA;
    logic [1:0] PER_WE;
    logic [15:0] PER_WDATA;
    logic [2:0][1:0] CMP_WE;
    logic [15:0] CMP_WDATA;
    logic EVENT_IN;
    logic [15:0] CNT;
    logic [15:0] PER;
    logic [2:0][15:0] CMP;
    logic [7:0] INTERRUPT_FLAG;
    logic IRQ;
    stm_pkg::stm_events_t EVENTS;
    logic [5:0] WAVE_OUT;
    int err_total;
    int checks_done;
    logic mon_on;
    stm_pkg::stm_events_t evq[$];

    stm_timer dut
    (
        .CLK(CLK), .NRST(NRST), .CTRL(CTRL), .INT_ENABLE(INT_ENABLE), .FLAG_CLEAR(FLAG_CLEAR),
        .IDLE_SLEEP(IDLE_SLEEP), .CNT_WE(CNT_WE), .CNT_WDATA(CNT_WDATA), .PER_WE(PER_WE),
        .PER_WDATA(PER_WDATA), .CMP_WE(CMP_WE), .CMP_WDATA(CMP_WDATA), .EVENT_IN(EVENT_IN),
        .CNT(CNT), .PER(PER), .CMP(CMP), .INTERRUPT_FLAG(INTERRUPT_FLAG), .IRQ(IRQ),
        .EVENTS(EVENTS), .WAVE_OUT(WAVE_OUT)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (err_total == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Byte strobes are independent, so a partial write must leave the other byte alone.
    task automatic wr(input int sel, input logic [1:0] be, input logic [15:0] v);
        @(posedge CLK);
        CNT_WDATA <= v;
        PER_WDATA <= v;
        CMP_WDATA <= v;
        if (sel == 0)
            CNT_WE <= be;
        else if (sel == 1)
            PER_WE <= be;
        else
            CMP_WE[sel-2] <= be;
        @(posedge CLK);
        CNT_WE <= 2'h0;
        PER_WE <= 2'h0;
        CMP_WE <= '0;
    endtask

    initial
    begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    // Only the order of event pulses is compared, so prescaler phase does not matter here.
    always @(posedge CLK)
    begin
        if (mon_on && EVENTS !== 5'h00)
        begin
            check(16'(EVENTS), 16'(evq.pop_front()));
            if (evq.size() == 0)
                mon_on = 1'b0;
        end
    end

    initial
    begin
        repeat (20000) @(posedge CLK);
        err_total++;
        close_out();
    end

    initial
    begin
        logic [7:0] l, h, pl, ph, fl, c0;
        logic [7:0] cl [3], ch [3];
        logic [15:0] c1, c2, cmp0v;
        stm_pkg::stm_events_t ev;
        stm_pkg::stm_event_action_select_t act [10];
        stm_pkg::stm_prescale_t pre [10];
        logic cn [10];
        logic sp [10];
        int pat [10];
        logic [15:0] dl [10];
        act = '{stm_pkg::STM_EV_POSEDGE, stm_pkg::STM_EV_ANYEDGE, stm_pkg::STM_EV_HIGH,
            stm_pkg::STM_EV_HIGH, stm_pkg::STM_EV_DIR, stm_pkg::STM_EV_DIR, stm_pkg::STM_EV_HIGH,
            stm_pkg::STM_EV_HIGH, stm_pkg::STM_EV_HIGH, stm_pkg::STM_EV_DIR};
        pre = '{stm_pkg::STM_DIV1, stm_pkg::STM_DIV1, stm_pkg::STM_DIV1, stm_pkg::STM_DIV2,
            stm_pkg::STM_DIV1, stm_pkg::STM_DIV1, stm_pkg::STM_DIV4, stm_pkg::STM_DIV8,
            stm_pkg::STM_DIV1, stm_pkg::STM_DIV1};
        cn = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
        sp = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
        pat = '{2, 2, 0, 1, 1, 0, 0, 1, 0, 0};
        dl = '{16'h0004, 16'h0008, 16'h0000, 16'h0004, 16'hFFF8, 16'h0008, 16'h0002, 16'hFFFF,
            16'hF7F8, 16'hF7F8};
        NRST = 1'b0;
        CTRL = '0;
        INT_ENABLE = 8'h00;
        FLAG_CLEAR = 8'h00;
        IDLE_SLEEP = 1'b1;
        CNT_WE = 2'h0;
        CNT_WDATA = 16'h0000;
        PER_WE = 2'h0;
        PER_WDATA = 16'h0000;
        CMP_WE = '0;
        CMP_WDATA = 16'h0000;
        EVENT_IN = 1'b0;
        mon_on = 1'b0;
        err_total = 0;
        checks_done = 0;
        void'($urandom(32'h0935));
        repeat (8) @(posedge CLK);
        check(CNT, 16'h0000);
        check(PER, 16'hFFFF);
        check(16'(INTERRUPT_FLAG), 16'h0000);
        @(posedge CLK);
        NRST <= 1'b1;
        for (int r = 0; r < 2; r++)
        begin
            @(posedge CLK);
            CTRL.enable <= 1'b0;
            CTRL.split_mode_enable <= 1'b1;
            CTRL.waveform_mode_select <= stm_pkg::STM_WG_SINGLE_SLOPE_PWM;
            CTRL.prescale_select <= stm_pkg::STM_DIV1;
            pl = 8'($urandom_range(7, 1));
            ph = 8'($urandom_range(7, 1));
            wr(0, 2'h3, 16'h0000);
            wr(1, 2'h1, {8'h00, pl});
            wr(1, 2'h2, {ph, 8'h00});
            for (int i = 0; i < 3; i++)
            begin
                cl[i] = 8'($urandom_range(7, 1));
                c0 = 8'($urandom_range(7, 0));
                ch[i] = c0;
                if (i == 0)
                    cmp0v = {c0, cl[i]};
                wr(2 + i, 2'h3, {c0, cl[i]});
            end
            check(PER, {ph, pl});
            // Sixteen ticks cover every low and high period, so flags reach their final set.
            l = 8'h00;
            h = 8'h00;
            fl = 8'h00;
            for (int t = 0; t < 16; t++)
            begin
                ev = '0;
                for (int i = 0; i < 3; i++)
                    ev.cmp[i] = (l == cl[i]);
                ev.overflow_or_low_underflow_event = (l == 8'h00);
                l = (l == 8'h00) ? pl : l - 8'h01;
                ev.high_underflow = (h == 8'h00);
                h = (h == 8'h00) ? ph : h - 8'h01;
                if (ev != '0)
                begin
                    evq.push_back(ev);
                    fl = fl | {1'b0, ev.cmp, 2'b00, ev.high_underflow, ev.overflow_or_low_underflow_event};
                end
            end
            @(posedge CLK);
            FLAG_CLEAR <= 8'hFF;
            @(posedge CLK);
            FLAG_CLEAR <= 8'h00;
            mon_on = 1'b1;
            CTRL.enable <= 1'b1;
            for (int k = 0; k < 300 && mon_on; k++)
                @(posedge CLK);
            check(16'(mon_on), 16'h0000);
            CTRL.enable <= 1'b0;
            repeat (3) @(posedge CLK);
            #1 check(16'(INTERRUPT_FLAG), 16'(fl));
            for (int b = 0; b < 8; b++)
            begin
                @(posedge CLK);
                INT_ENABLE <= 8'(1 << b);
                @(posedge CLK);
                #1 check(16'(IRQ), 16'(fl[b]));
            end
            @(posedge CLK);
            INT_ENABLE <= 8'h01;
            FLAG_CLEAR <= 8'h01;
            @(posedge CLK);
            FLAG_CLEAR <= 8'h00;
            @(posedge CLK);
            #1 check(16'(INTERRUPT_FLAG), 16'(fl & 8'hFE));
            check(16'(IRQ), 16'h0000);
            // A known count makes every channel's duty decision predictable.
            wr(0, 2'h3, 16'h0404);
            repeat (2) @(posedge CLK);
            #1;
            for (int i = 0; i < 3; i++)
            begin
                check(16'(WAVE_OUT[i]), 16'(8'h04 < cl[i]));
                check(16'(WAVE_OUT[i + 3]), 16'(8'h04 < ch[i]));
            end
            @(posedge CLK);
            CTRL.split_mode_enable <= 1'b0;
            repeat (2) @(posedge CLK);
            #1 check(PER, {ph, pl});
            check(CMP[0], cmp0v);
        end
        for (int i = 0; i < 10; i++)
        begin
            @(posedge CLK);
            CTRL.enable <= 1'b0;
            @(posedge CLK);
            CTRL <= '{enable: 1'b0, prescale_select: pre[i], split_mode_enable: sp[i],
                waveform_mode_select: sp[i] ? stm_pkg::STM_WG_SINGLE_SLOPE_PWM : stm_pkg::STM_WG_NORMAL,
                event_action_select: act[i], count_on_event_enable: cn[i], dir_down: i == 7};
            EVENT_IN <= (pat[i] == 1);
            wr(1, 2'h3, 16'hFFFF);
            @(posedge CLK);
            CTRL.enable <= 1'b1;
            wr(0, 2'h3, 16'h8080);
            repeat (8) @(posedge CLK);
            #1 c1 = CNT;
            if (pat[i] == 2)
            begin
                repeat (8)
                begin
                    repeat (4) @(posedge CLK);
                    EVENT_IN <= ~EVENT_IN;
                end
                repeat (6) @(posedge CLK);
            end
            else
                repeat (8) @(posedge CLK);
            #1 c2 = CNT;
            check(c2, c1 + dl[i]);
        end
        close_out();
    end
endmodule // tb
